/* rtl/adc_readout_defines.svh */
// Constants for the dual converter ready/strobe pin and serial readout.
// Assumes a single 200 MHz reference clock; included by bare name.
`ifndef ADC_READOUT_DEFINES_SVH
`define ADC_READOUT_DEFINES_SVH

// Clock and timing
`define ADR_CLK_PERIOD_NS      5
`define ADR_READY_INIT_TIME_NS 900000
`define ADR_READY_INIT_CYCLES  ((`ADR_READY_INIT_TIME_NS + `ADR_CLK_PERIOD_NS - 1) / `ADR_CLK_PERIOD_NS)
`define ADR_DRDY_CYCLES        60
`define ADR_OSC_DIV            4

// Output word layout
`define ADR_WORD_BITS          16
`define ADR_WORD_MSB           15
`define ADR_NARROW_RES         14

// Output protocol field codes
`define ADR_PROTO_LEGACY       3'h0
`define ADR_PROTO_RETIMER      3'h4

// Bit positions in the synchronised pin vector
`define ADR_PIN_PD             0
`define ADR_PIN_CONV           1
`define ADR_PIN_CS             2
`define ADR_PIN_SCLK           3
`define ADR_PIN_COUNT          4

`endif

/* rtl/adc_readout_pkg.sv */
// Types shared by the readout block and its testbench.
// Assumes adc_readout_defines.svh is on the include path.
`include "adc_readout_defines.svh"

package adc_readout_pkg;

    // One simultaneous sample: a word per converter
    typedef struct packed {
        logic [`ADR_WORD_MSB:0] word_a;  // First converter
        logic [`ADR_WORD_MSB:0] word_b;  // Second converter
    } pair_t;

    // Read protocol selection
    typedef struct packed {
        logic [2:0] output_protocol_field;  // Protocol code
        logic       clock_polarity_bit;     // Idle level of serial clock
        logic       clock_phase_bit;        // Launch on first edge when set
    } proto_cfg_t;

endpackage

/* rtl/adc_readout.sv */
// Ready/strobe pin, output word formatting and legacy single-lane readout
// for a dual simultaneous-sampling converter, plus its sample buffer.
// Assumes pins are asynchronous to ref_clk and the serial clock is slow
// enough (period well above four ref_clk cycles) to be oversampled.
// Function
// - Shared pin: strobe when selected, else ready
// - Ready high at wakeup, low after 0.9 ms
// - Ready low converting, high after ready delay
// - Select falling returns ready low
// - Re-timer data aligned to strobe rising edges
// - Strobe from serial clock or internal oscillator
// - Strobe held low outside re-timer protocols
// - Each converter: own 16-bit two's-complement word
// - Narrow left-aligned: low two bits zero
// - Narrow right-aligned: top bits sign extension
// - Register read replaces conversion result
// - Fixed pattern replaces conversion data
// - Converter words on their own lanes
// - Reset selects legacy, polarity 0, phase 0
// - Code zero selects legacy; polarity, phase bits
// - Phase 0 MSB at select; phase 1 first edge
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_defines.svh"

// Small flop-based FIFO with registered flags
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW-1:0]    wr_ptr;       // Next write slot
    logic [AW-1:0]    rd_ptr;       // Head slot
    logic [AW:0]      count;        // Words held
    logic [AW:0]      next_count;   // Count after this cycle
    logic             push;         // Accepted write
    logic             pop;          // Accepted read

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Count follows pushes and pops together
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Storage written on each accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // Flags registered so both sides see flop outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count     <= next_count;
            in_ready  <= (next_count < (AW + 1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule

// Ready/strobe pin and dual-lane serial readout
module adc_readout
    import adc_readout_pkg::*;
#(
    parameter int RESOLUTION  = `ADR_WORD_BITS,
    parameter int INIT_CYCLES = `ADR_READY_INIT_CYCLES,
    parameter int DRDY_CYCLES = `ADR_DRDY_CYCLES,
    parameter int FIFO_DEPTH  = 4
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // Device pins
    input  wire logic                   powerdown_reset_pin_n,
    input  wire logic                   conversion_start,
    input  wire logic                   cs_n,
    input  wire logic                   sclk,
    output logic                        ready_strobe,
    output logic                        first_converter_lane0,
    output logic                        second_converter_lane0,
    // Configuration bits
    input  wire proto_cfg_t             proto_cfg,
    input  wire logic                   ready_mask,
    input  wire logic                   data_right_aligned,
    input  wire logic                   fixed_pattern_en,
    input  wire logic [`ADR_WORD_MSB:0] fixed_pattern,
    input  wire logic                   register_read_en,
    input  wire logic [`ADR_WORD_MSB:0] register_read_data,
    input  wire logic                   strobe_from_sclk,
    // Converter core results
    input  wire logic                   core_valid,
    input  wire pair_t                  core_result,
    output logic                        core_ready
);
    logic [`ADR_PIN_COUNT-1:0] pin_s1;      // First sync stage
    logic [`ADR_PIN_COUNT-1:0] pin_s2;      // Second sync stage
    logic [`ADR_PIN_COUNT-1:0] pin_q;       // Previous value for edges
    logic                      in_reset;    // Power-down/reset held
    logic                      conv_rise;   // Conversion start edge
    logic                      cs_fall;     // Frame begins
    logic                      sclk_rise;   // Serial clock rising
    logic                      sclk_fall;   // Serial clock falling
    proto_cfg_t                cfg;         // Config in force
    logic                      retimer;     // Re-timer protocol active
    logic [17:0]               init_cnt;    // Wakeup timer
    logic                      init_busy;   // Wakeup in progress
    logic [15:0]               conv_cnt;    // Ready delay timer
    logic                      conv_busy;   // Conversion in progress
    logic                      conv_done;   // Result readable
    logic                      ready_level; // Ready function level
    logic [1:0]                osc_div;     // Oscillator divider
    logic                      osc;         // Internal strobe clock
    logic                      osc_rise;    // Oscillator rising event
    logic                      strobe_sig;  // Strobe function level
    logic                      launch;      // Launch edge this cycle
    logic                      first_pend;  // MSB waits for first edge
    pair_t                     last_pair;   // Last buffered sample
    pair_t                     fifo_head;   // Buffer head
    logic                      fifo_valid;  // Buffer not empty
    pair_t                     next_word;   // Words loaded at frame start
    pair_t                     shreg;       // Shift registers

    // Justify a raw result into the 16-bit word
    function automatic logic [`ADR_WORD_MSB:0] align_word(
        input logic [`ADR_WORD_MSB:0] raw,
        input logic                   right
    );
        logic [`ADR_NARROW_RES-1:0] narrow;
        narrow = raw[`ADR_NARROW_RES-1:0];
        if (RESOLUTION != `ADR_NARROW_RES) begin
            align_word = raw;
        end else if (right) begin
            align_word = {{2{narrow[`ADR_NARROW_RES-1]}}, narrow};
        end else begin
            align_word = {narrow, 2'b00};
        end
    endfunction

    // Content of one lane's word; register data outranks the pattern
    function automatic logic [`ADR_WORD_MSB:0] pick_word(
        input logic [`ADR_WORD_MSB:0] raw
    );
        if (register_read_en) begin
            pick_word = register_read_data;
        end else if (fixed_pattern_en) begin
            pick_word = fixed_pattern;
        end else begin
            pick_word = align_word(raw, data_right_aligned);
        end
    endfunction

    // Pins cross into ref_clk; only the second stage and its delayed copy are read
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1 <= 4'h5;
            pin_s2 <= 4'h5;
            pin_q  <= 4'h5;
        end else begin
            pin_s1 <= {sclk, cs_n, conversion_start, powerdown_reset_pin_n};
            pin_s2 <= pin_s1;
            pin_q  <= pin_s2;
        end
    end

    assign in_reset  = !pin_s2[`ADR_PIN_PD];
    assign conv_rise = pin_s2[`ADR_PIN_CONV] && !pin_q[`ADR_PIN_CONV];
    assign cs_fall   = !pin_s2[`ADR_PIN_CS] && pin_q[`ADR_PIN_CS];
    assign sclk_rise = pin_s2[`ADR_PIN_SCLK] && !pin_q[`ADR_PIN_SCLK];
    assign sclk_fall = !pin_s2[`ADR_PIN_SCLK] && pin_q[`ADR_PIN_SCLK];
    assign retimer   = (cfg.output_protocol_field == `ADR_PROTO_RETIMER);

    // Config loads only between frames; the reset pin forces the default at any time
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= '{`ADR_PROTO_LEGACY, 1'b0, 1'b0};
        end else if (in_reset) begin
            cfg <= '{`ADR_PROTO_LEGACY, 1'b0, 1'b0};
        end else if (pin_s2[`ADR_PIN_CS] && pin_q[`ADR_PIN_CS]) begin
            cfg <= proto_cfg;
        end
    end

    // Wakeup timer restarts while the reset pin is held low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            init_busy <= 1'b1;
            init_cnt  <= '0;
        end else if (in_reset) begin
            init_busy <= 1'b1;
            init_cnt  <= '0;
        end else if (init_busy) begin
            if (init_cnt == 18'(INIT_CYCLES - 1)) begin
                init_busy <= 1'b0;
            end
            init_cnt <= init_cnt + 1'b1;
        end
    end

    // Conversion timer; a new start restarts it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_busy <= 1'b0;
            conv_cnt  <= '0;
        end else if (in_reset) begin
            conv_busy <= 1'b0;
            conv_cnt  <= '0;
        end else if (conv_rise) begin
            conv_busy <= 1'b1;
            conv_cnt  <= '0;
        end else if (conv_busy) begin
            if (conv_done) begin
                conv_busy <= 1'b0;
            end
            conv_cnt <= conv_cnt + 1'b1;
        end
    end

    assign conv_done = conv_busy && !conv_rise && (conv_cnt == 16'(DRDY_CYCLES - 1));

    // Ready level; a finishing conversion outranks a select fall
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_level <= 1'b1;
        end else if (in_reset) begin
            ready_level <= 1'b1;
        end else if (init_busy) begin
            if (init_cnt == 18'(INIT_CYCLES - 1)) begin
                ready_level <= 1'b0;
            end
        end else if (conv_done) begin
            ready_level <= 1'b1;
        end else if (conv_rise) begin
            ready_level <= 1'b0;
        end else if (cs_fall) begin
            ready_level <= 1'b0;
        end
    end

    // Internal oscillator from a divider enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_div <= '0;
            osc     <= 1'b0;
        end else begin
            osc_div <= osc_div + 1'b1;
            if (osc_div == 2'(`ADR_OSC_DIV - 1)) begin
                osc <= !osc;
            end
        end
    end

    assign osc_rise = (osc_div == 2'(`ADR_OSC_DIV - 1)) && !osc;

    // Strobe lags the launch by a cycle so data settle before it rises
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_sig <= 1'b0;
        end else if (!retimer) begin
            strobe_sig <= 1'b0;
        end else begin
            strobe_sig <= strobe_from_sclk ? pin_q[`ADR_PIN_SCLK] : osc;
        end
    end

    // Pin mux is registered; reads ready when select is high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_strobe <= 1'b1;
        end else if (!pin_s2[`ADR_PIN_CS]) begin
            ready_strobe <= retimer && strobe_sig;
        end else begin
            ready_strobe <= ready_level && !ready_mask;
        end
    end

    // Results wait in the buffer; core stalls when it is full
    sample_fifo #(
        .WIDTH ($bits(pair_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (core_valid),
        .in_data   (core_result),
        .in_ready  (core_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_head),
        .out_ready (cs_fall)
    );

    // Frame with an empty buffer repeats the last sample
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_pair <= '0;
        end else if (cs_fall && fifo_valid) begin
            last_pair <= fifo_head;
        end
    end

    always_comb begin
        next_word.word_a = pick_word(fifo_valid ? fifo_head.word_a : last_pair.word_a);
        next_word.word_b = pick_word(fifo_valid ? fifo_head.word_b : last_pair.word_b);
    end

    // Launch edge: strobe rise in re-timer, else trailing for phase 0, leading for phase 1
    always_comb begin
        launch = 1'b0;
        if (!pin_s2[`ADR_PIN_CS] && !cs_fall) begin
            if (retimer) begin
                launch = strobe_from_sclk ? sclk_rise : osc_rise;
            end else if (cfg.clock_phase_bit) begin
                launch = cfg.clock_polarity_bit ? sclk_fall : sclk_rise;
            end else begin
                launch = cfg.clock_polarity_bit ? sclk_rise : sclk_fall;
            end
        end
    end

    // Shift out MSB first, one bit per launch, zeros after the word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shreg                  <= '0;
            first_pend             <= 1'b0;
            first_converter_lane0  <= 1'b0;
            second_converter_lane0 <= 1'b0;
        end else if (cs_fall) begin
            shreg      <= next_word;
            first_pend <= cfg.clock_phase_bit || retimer;
            if (!cfg.clock_phase_bit && !retimer) begin
                first_converter_lane0  <= next_word.word_a[`ADR_WORD_MSB];
                second_converter_lane0 <= next_word.word_b[`ADR_WORD_MSB];
            end
        end else if (launch) begin
            if (first_pend) begin
                first_pend             <= 1'b0;
                first_converter_lane0  <= shreg.word_a[`ADR_WORD_MSB];
                second_converter_lane0 <= shreg.word_b[`ADR_WORD_MSB];
            end else begin
                shreg.word_a           <= {shreg.word_a[`ADR_WORD_MSB-1:0], 1'b0};
                shreg.word_b           <= {shreg.word_b[`ADR_WORD_MSB-1:0], 1'b0};
                first_converter_lane0  <= shreg.word_a[`ADR_WORD_MSB-1];
                second_converter_lane0 <= shreg.word_b[`ADR_WORD_MSB-1];
            end
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    property p_ready_mux;
        pin_s2[`ADR_PIN_CS] |=> ready_strobe == $past(ready_level && !ready_mask);
    endproperty
    a_ready_mux: assert property (p_ready_mux) else $error("ready pin mismatch");

    property p_wake_high;
        $rose(pin_s2[`ADR_PIN_PD]) |=> ready_level [*8];
    endproperty
    a_wake_high: assert property (p_wake_high) else $error("ready low in wakeup");

    property p_conv_low;
        conv_rise && !in_reset && !init_busy |=> !ready_level;
    endproperty
    a_conv_low: assert property (p_conv_low) else $error("ready not low at start");

    property p_conv_done;
        conv_done && !in_reset && !init_busy |=> ready_level && !conv_busy;
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("ready not set at done");

    property p_cs_low;
        cs_fall && !conv_done && !in_reset && !init_busy |=> !ready_level;
    endproperty
    a_cs_low: assert property (p_cs_low) else $error("ready not cleared at select");

    property p_strobe_low;
        !pin_s2[`ADR_PIN_CS] && !retimer |=> !ready_strobe;
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe not low");

    property p_reg_read;
        cs_fall && register_read_en |=> shreg.word_a == $past(register_read_data);
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("register word missing");

    property p_reset_cfg;
        in_reset |=> cfg == '{`ADR_PROTO_LEGACY, 1'b0, 1'b0};
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("default protocol lost");

    property p_msb_phase0;
        cs_fall && !cfg.clock_phase_bit && !retimer
            |=> first_converter_lane0 == shreg.word_a[`ADR_WORD_MSB];
    endproperty
    a_msb_phase0: assert property (p_msb_phase0) else $error("MSB not at select");

    property p_shift;
        launch && !first_pend && !cs_fall
            |=> second_converter_lane0 == $past(shreg.word_b[`ADR_WORD_MSB-1]);
    endproperty
    a_shift: assert property (p_shift) else $error("lane bit out of order");
endmodule
`default_nettype wire

/* dv/host_reader.sv */
// Host model: drives select and the serial clock, shifts in both lanes.
// Assumes the device launches bits on the edges its phase setting names.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // Frame control
    input  wire logic   go,
    input  wire logic   cpol,
    input  wire logic   cpha,
    // Serial pins
    output logic        cs_n,
    output logic        sclk,
    input  wire logic   lane_a,
    input  wire logic   lane_b,
    // Received words
    output logic [15:0] word_a,
    output logic [15:0] word_b,
    output logic        done
);
    localparam realtime HALF = 62.5;  // Half of the 125 ns link clock
    initial begin
        cs_n = 1'b1;  // No data-in pin modelled: host input stays a no-op
        sclk = 1'b0;
        done = 1'b0;
        word_a = '0;
        word_b = '0;
    end
    // Clock stands at its idle level between frames
    always @(cpol) if (cs_n) sclk = cpol;
    // Shift one bit from each lane
    task automatic take;
        word_a = {word_a[14:0], lane_a};
        word_b = {word_b[14:0], lane_b};
    endtask
    // One frame per rise of go; sixteen full periods cover the 15.5 minimum
    always @(posedge go) begin
        done = 1'b0;
        cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            #HALF;
            if (!cpha) take();
            sclk = ~cpol;
            #HALF;
            if (cpha) take();
            sclk = cpol;
        end
        #HALF;
        cs_n = 1'b1;
        done = 1'b1;
    end
endmodule
`default_nettype wire

/* dv/adc_readout_tb.sv */
// Self-checking bench for the readout block with a host model on its pins.
// Assumes short init and ready delays given through the parameters.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_tb;
    import adc_readout_pkg::*;
    localparam int INIT = 200;  // Shortened wakeup count
    localparam int DRDY = 20;   // Shortened conversion time
    logic ref_clk = 1'b0, reset_n = 1'b0, conversion_start = 1'b0, go = 1'b0;
    logic fp_en = 1'b0, rd_en = 1'b0, core_valid = 1'b0, pd_n = 1'b1, mask = 1'b0;
    logic [15:0] fp = '0, rd = '0, rnd = 16'haefe;  // Seed 44798
    proto_cfg_t proto_cfg = '0;
    pair_t core_result = '0, p;
    logic cs_n, sclk, ready_strobe, lane_a, lane_b, core_ready, done;
    logic [15:0] word_a, word_b;
    pair_t exp_q[$];  // Expected words, oldest first
    int n_errors = 0, num_checks = 0, cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    adc_readout #(.INIT_CYCLES(INIT), .DRDY_CYCLES(DRDY)) u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .powerdown_reset_pin_n(pd_n),
        .conversion_start(conversion_start), .cs_n(cs_n), .sclk(sclk),
        .ready_strobe(ready_strobe), .first_converter_lane0(lane_a),
        .second_converter_lane0(lane_b), .proto_cfg(proto_cfg), .ready_mask(mask),
        .data_right_aligned(1'b0), .fixed_pattern_en(fp_en), .fixed_pattern(fp),
        .register_read_en(rd_en), .register_read_data(rd), .strobe_from_sclk(1'b0),
        .core_valid(core_valid), .core_result(core_result), .core_ready(core_ready));

    host_reader u_host (
        .go(go), .cpol(proto_cfg.clock_polarity_bit), .cpha(proto_cfg.clock_phase_bit),
        .cs_n(cs_n), .sclk(sclk), .lane_a(lane_a), .lane_b(lane_b),
        .word_a(word_a), .word_b(word_b), .done(done));

    // Random source for result words
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Wait out the wakeup: ready high first, low once the count ends
    task automatic wake;
        repeat (INIT / 2) @(posedge ref_clk);
        check("ready at wakeup", 32'h1, ready_strobe);
        repeat (INIT / 2 + 10) @(posedge ref_clk);
        check("ready after init", 32'h0, ready_strobe);
    endtask

    // Hand one sample to the buffer, held until it is taken
    task automatic push(input pair_t v);
        @(posedge ref_clk);
        core_valid <= 1'b1;
        core_result <= v;
        do @(posedge ref_clk); while (core_ready !== 1'b1);
        core_valid <= 1'b0;
    endtask

    // Convert, wait for ready, then let the host read one frame
    task automatic frame(input logic [1:0] mode);
        int n;
        @(posedge ref_clk);
        proto_cfg <= {3'h0, mode};
        conversion_start <= 1'b1;
        repeat (6) @(posedge ref_clk);
        conversion_start <= 1'b0;
        check("ready in conversion", 32'h0, ready_strobe);
        n = 0;
        while (ready_strobe !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        check("ready done", 32'h1, ready_strobe);
        check("ready delay", 32'h1, n >= DRDY - 6);
        go <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check("strobe in frame", 32'h0, ready_strobe);
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        go <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check("ready after frame", 32'h0, ready_strobe);
    endtask

    // Compare each finished frame with the oldest note
    always @(posedge done) begin
        if (exp_q.size() == 0)
            check("spare frame", 32'h0, 32'h1);
        else
            check("lanes", exp_q.pop_front(), {word_a, word_b});
    end

    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        wake();
        // Every polarity and phase, default mode first
        for (int m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            p.word_a = rnd;
            rnd = lfsr(rnd);
            p.word_b = rnd;
            push(p);
            exp_q.push_back(p);
            frame(m[1:0]);
        end
        // Wide-read host masks ready; lifting the mask shows it again
        mask <= 1'b1;
        conversion_start <= 1'b1;
        repeat (DRDY + 10) @(posedge ref_clk);
        check("masked ready", 32'h0, ready_strobe);
        mask <= 1'b0;
        conversion_start <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("unmasked ready", 32'h1, ready_strobe);
        // Pattern alone, then register read over the pattern
        for (int k = 1; k < 3; k++) begin
            fp_en <= 1'b1;
            rd_en <= (k == 2);
            fp <= 16'h5a3c;
            rd <= 16'hc3a5;
            push(p);
            exp_q.push_back((k == 2) ? {2{16'hc3a5}} : {2{16'h5a3c}});
            frame(2'b00);
        end
        fp_en <= 1'b0;
        rd_en <= 1'b0;
        // Pin reset in mid-run: ready held high, then a fresh wakeup
        pd_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("ready in pin reset", 32'h1, ready_strobe);
        pd_n <= 1'b1;
        wake();
        // Fill the buffer until it refuses, then drain past empty
        for (int j = 0; j < 4; j++) begin
            rnd = lfsr(rnd);
            p = {rnd, ~rnd};
            push(p);
            exp_q.push_back(p);
        end
        repeat (2) @(posedge ref_clk);
        check("buffer full", 32'h0, core_ready);
        exp_q.push_back(p);
        for (int j = 0; j < 5; j++) frame(2'b00);
        check("buffer free", 32'h1, core_ready);
        summarize();
    end
endmodule
`default_nettype wire
